// ==== core/freq_word_conv.sv ====
// Conversion between scaled frequency words, kHz values and divisor table entries.
`timescale 1ns/1ps
module freq_word_conv
    import swcfg_pkg::*;
(
    input  wire logic [15:0] lin_word_i,
    input  wire logic [6:0]  scan_div_i,
    input  wire logic [6:0]  act_div_i,
    output logic      [15:0] target_khz_o,
    output logic      [15:0] scan_khz_o,
    output logic      [15:0] act_word_o
);

    logic        [15:0] khz_tab [DIV_LO:DIV_HI];
    logic signed [4:0]  exp_s;
    logic signed [10:0] mant_s;
    logic        [31:0] wide;
    logic        [15:0] act_khz;

    // Frequency for every legal divisor, fixed at elaboration.
    genvar g;
    generate
        for (g = DIV_LO; g <= DIV_HI; g++)
        begin : g_tab
            assign khz_tab[g] = khz_of_div(g);
        end
    endgenerate

    // Decode mantissa times two to the exponent; non-positive values give zero.
    always_comb
    begin
        exp_s  = signed'(lin_word_i[EXP_MSB:EXP_LSB]);
        mant_s = signed'(lin_word_i[MANT_MSB:0]);
        wide   = 32'h0;
        if (mant_s > 11'sh000)
        begin
            if (exp_s >= 5'sh00)
            begin
                wide = {21'h0, mant_s} << exp_s[3:0];
            end
            else
            begin
                wide = {21'h0, mant_s} >> $unsigned(-exp_s);
            end
        end
        target_khz_o = (wide > 32'h0000FFFF) ? 16'hFFFF : wide[15:0];
    end

    // Actual frequency is reported with the smallest exponent that fits.
    always_comb
    begin
        scan_khz_o = khz_tab[scan_div_i];
        act_khz    = khz_tab[act_div_i];
        if (act_khz > MANT_MAX)
        begin
            act_word_o = {EXP_ONE, act_khz[11:1]};
        end
        else
        begin
            act_word_o = {EXP_ZERO, act_khz[10:0]};
        end
    end

endmodule : freq_word_conv

// ==== core/phase_step_calc.sv ====
// Phase offset of both phases, in 22.5 degree steps, from an interleave word.
`timescale 1ns/1ps
module phase_step_calc
    import swcfg_pkg::*;
(
    input  wire logic [7:0] ilv_i,
    input  wire logic       solo_i,
    output logic      [4:0] ph0_o,
    output logic      [4:0] ph1_o
);

    logic [4:0] num;
    logic [4:0] pos;
    logic [9:0] quot;
    logic [8:0] steps;
    logic [8:0] steps_m1;
    logic [4:0] wrapped;
    logic [4:0] ph1_raw;

    // Doubling before the divide lets a half step round upward exactly.
    always_comb
    begin
        num      = (ilv_i[NUM_MSB:NUM_LSB] == 4'h0) ? GROUP_MAX : {1'b0, ilv_i[NUM_MSB:NUM_LSB]};
        pos      = (ilv_i[POS_MSB:POS_LSB] == 4'h0) ? GROUP_MAX : {1'b0, ilv_i[POS_MSB:POS_LSB]};
        quot     = {pos, 5'h00} / {5'h00, num};
        steps    = 9'((quot + 10'h001) >> 1);
        steps_m1 = steps - 9'h001;
        if (steps > {4'h0, STEPS_FULL})
        begin
            wrapped = {1'b0, steps_m1[3:0]} + 5'h01;
        end
        else
        begin
            wrapped = steps[4:0];
        end
        ph0_o   = solo_i ? 5'h00 : wrapped;
        ph1_raw = ph0_o + STEPS_HALF;
        ph1_o   = (ph1_raw > STEPS_FULL) ? ph1_raw - STEPS_FULL : ph1_raw;
    end

endmodule : phase_step_calc

// ==== core/swcfg_pkg.sv ====
// Constants and types shared by the switching and phase configuration registers.
package swcfg_pkg;

    // Command codes on the management port.
    localparam logic [7:0]  CMD_FREQ   = 8'h33;
    localparam logic [7:0]  CMD_ILV    = 8'h37;
    localparam logic [7:0]  CMD_GAIN   = 8'h38;

    // Base clock of the switching generator and the legal divisor range.
    localparam int unsigned BASE_MHZ   = 16;
    localparam int unsigned BASE_KHZ   = BASE_MHZ * 1000;
    localparam logic [6:0]  DIV_MIN    = 7'h0C;
    localparam logic [6:0]  DIV_MAX    = 7'h50;
    localparam int          DIV_LO     = 12;
    localparam int          DIV_HI     = 80;

    // Exponent and mantissa fields of a two-byte scaled word.
    localparam int          EXP_MSB    = 15;
    localparam int          EXP_LSB    = 11;
    localparam int          MANT_MSB   = 10;
    localparam logic [15:0] MANT_MAX   = 16'h03FF;
    localparam logic [4:0]  EXP_ZERO   = 5'h00;
    localparam logic [4:0]  EXP_ONE    = 5'h01;

    // Interleave word fields.
    localparam int          NUM_MSB    = 7;
    localparam int          NUM_LSB    = 4;
    localparam int          POS_MSB    = 3;
    localparam int          POS_LSB    = 0;
    localparam logic [4:0]  GROUP_MAX  = 5'h10;

    // Phase offsets are counted in steps of 22.5 degrees.
    localparam logic [4:0]  STEPS_FULL = 5'h10;
    localparam logic [4:0]  STEPS_HALF = 5'h08;

    // Reset values and the last start-up settle count.
    localparam logic [15:0] GAIN_RST   = 16'hB2AE;
    localparam logic [15:0] DIFF_MAX   = 16'hFFFF;
    localparam logic [1:0]  SETTLE_END = 2'h2;

    // Sequencer states, Gray coded along strap, scan, idle.
    typedef enum logic [1:0] {
        ST_STRAP = 2'h0,
        ST_SCAN  = 2'h1,
        ST_IDLE  = 2'h3
    } cfg_state_t;

    // Switching frequency in kHz for a divisor, rounded to nearest.
    function automatic logic [15:0] khz_of_div(input int unsigned n);
        return 16'((BASE_KHZ + n / 2) / n);
    endfunction : khz_of_div

endpackage : swcfg_pkg

// ==== core/switching_phase_config_regs.sv ====
// Switching frequency, interleave and current-sense gain command registers.
`timescale 1ns/1ps
module switching_phase_config_regs
    import swcfg_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RESETN_I,
    input  wire logic        CMD_WR_I,
    input  wire logic        CMD_RD_I,
    input  wire logic [7:0]  CMD_CODE_I,
    input  wire logic        CMD_PAGE_I,
    input  wire logic [15:0] CMD_WDATA_I,
    input  wire logic [15:0] SYNC_STRAP_I,
    input  wire logic [7:0]  CFG_STRAP_I,
    input  wire logic        SOLO_GROUP_I,
    output logic      [15:0] RD_DATA_O,
    output logic             RD_ACK_O,
    output logic             CMD_ERR_O,
    output logic             FREQ_BUSY_O,
    output logic      [6:0]  DIVISOR_O,
    output logic      [4:0]  PH0_STEP_O,
    output logic      [4:0]  PH1_STEP_O,
    output logic      [15:0] GAIN0_O,
    output logic      [15:0] GAIN1_O
);

    // Every flip-flop of the block lives in this one record.
    typedef struct packed {
        cfg_state_t  state;
        logic [1:0]  settle;
        logic [15:0] sync_s1;
        logic [15:0] sync_s2;
        logic [7:0]  cfg_s1;
        logic [7:0]  cfg_s2;
        logic        solo_s1;
        logic        solo_s2;
        logic [15:0] target;
        logic [6:0]  scan_n;
        logic [6:0]  best_n;
        logic [15:0] best_diff;
        logic [6:0]  divisor;
        logic        busy;
        logic [7:0]  ilv0;
        logic [7:0]  ilv1;
        logic [15:0] gain0;
        logic [15:0] gain1;
        logic [4:0]  ph0;
        logic [4:0]  ph1;
        logic [15:0] rd_data;
        logic        rd_ack;
        logic        cmd_err;
    } regs_t;

    localparam regs_t REGS_RST = '{
        state:     ST_STRAP,
        divisor:   DIV_MAX,
        scan_n:    DIV_MIN,
        best_n:    DIV_MIN,
        best_diff: DIFF_MAX,
        busy:      1'b1,
        ph1:       STEPS_HALF,
        gain0:     GAIN_RST,
        gain1:     GAIN_RST,
        default:   '0
    };

    regs_t       state_reg;
    regs_t       state_next;
    logic [15:0] conv_word;
    logic [15:0] conv_khz;
    logic [15:0] scan_khz;
    logic [15:0] act_word;
    logic [15:0] scan_diff;
    logic        scan_better;
    logic [4:0]  ph0_calc;
    logic [4:0]  ph1_calc;
    logic        cmd_ok;
    logic        freq_wr;

    // The converter serves the strap during start-up and the host afterwards.
    assign conv_word = (state_reg.state == ST_STRAP) ? state_reg.sync_s2 : CMD_WDATA_I;

    // Commands are taken only once the straps have been sampled.
    assign cmd_ok  = (CMD_WR_I || CMD_RD_I) && (state_reg.state != ST_STRAP);
    assign freq_wr = CMD_WR_I && (CMD_CODE_I == CMD_FREQ) && (state_reg.state != ST_STRAP);

    freq_word_conv freq_word_conv_inst (
        .lin_word_i   (conv_word),
        .scan_div_i   (state_reg.scan_n),
        .act_div_i    (state_reg.divisor),
        .target_khz_o (conv_khz),
        .scan_khz_o   (scan_khz),
        .act_word_o   (act_word)
    );

    // Both phases of the device are placed by the page 0 interleave word.
    phase_step_calc phase_step_calc_inst (
        .ilv_i  (state_reg.ilv0),
        .solo_i (state_reg.solo_s2),
        .ph0_o  (ph0_calc),
        .ph1_o  (ph1_calc)
    );

    // Distance between the candidate divisor and the requested frequency.
    always_comb
    begin
        if (scan_khz >= state_reg.target)
        begin
            scan_diff = scan_khz - state_reg.target;
        end
        else
        begin
            scan_diff = state_reg.target - scan_khz;
        end
        scan_better = (scan_diff < state_reg.best_diff);
    end

    // Next state: synchronisers, start-up, divisor search and command decode.
    always_comb
    begin
        state_next         = state_reg;
        state_next.sync_s1 = SYNC_STRAP_I;
        state_next.sync_s2 = state_reg.sync_s1;
        state_next.cfg_s1  = CFG_STRAP_I;
        state_next.cfg_s2  = state_reg.cfg_s1;
        state_next.solo_s1 = SOLO_GROUP_I;
        state_next.solo_s2 = state_reg.solo_s1;
        state_next.rd_ack  = 1'b0;
        state_next.cmd_err = 1'b0;
        state_next.ph0     = ph0_calc;
        state_next.ph1     = ph1_calc;

        case (state_reg.state)
            ST_STRAP:
            begin
                // The straps settle through the synchronisers before they are used.
                if (state_reg.settle == SETTLE_END)
                begin
                    state_next.target    = conv_khz;
                    state_next.ilv0      = state_reg.cfg_s2;
                    state_next.ilv1      = state_reg.cfg_s2;
                    state_next.scan_n    = DIV_MIN;
                    state_next.best_diff = DIFF_MAX;
                    state_next.state     = ST_SCAN;
                end
                else
                begin
                    state_next.settle = state_reg.settle + 2'h1;
                end
            end
            ST_SCAN:
            begin
                // One divisor per cycle; ties keep the higher frequency.
                if (scan_better)
                begin
                    state_next.best_diff = scan_diff;
                    state_next.best_n    = state_reg.scan_n;
                end
                if (state_reg.scan_n == DIV_MAX)
                begin
                    state_next.divisor = scan_better ? state_reg.scan_n : state_reg.best_n;
                    state_next.state   = ST_IDLE;
                end
                else
                begin
                    state_next.scan_n = state_reg.scan_n + 7'h01;
                end
            end
            default:
            begin
                state_next.state = ST_IDLE;
            end
        endcase

        // A read in the same cycle as a write returns the value before the write.
        if (cmd_ok)
        begin
            if (CMD_CODE_I == CMD_FREQ)
            begin
                // The page is ignored: one setting serves both channels.
                if (CMD_WR_I)
                begin
                    state_next.target    = conv_khz;
                    state_next.scan_n    = DIV_MIN;
                    state_next.best_diff = DIFF_MAX;
                    state_next.state     = ST_SCAN;
                end
                state_next.rd_data = act_word;
            end
            else if (CMD_CODE_I == CMD_ILV)
            begin
                if (CMD_WR_I && CMD_PAGE_I)
                begin
                    state_next.ilv1 = CMD_WDATA_I[7:0];
                end
                else if (CMD_WR_I)
                begin
                    state_next.ilv0 = CMD_WDATA_I[7:0];
                end
                state_next.rd_data = {8'h00, CMD_PAGE_I ? state_reg.ilv1 : state_reg.ilv0};
            end
            else if (CMD_CODE_I == CMD_GAIN)
            begin
                if (CMD_WR_I && CMD_PAGE_I)
                begin
                    state_next.gain1 = CMD_WDATA_I;
                end
                else if (CMD_WR_I)
                begin
                    state_next.gain0 = CMD_WDATA_I;
                end
                state_next.rd_data = CMD_PAGE_I ? state_reg.gain1 : state_reg.gain0;
            end
            else
            begin
                state_next.cmd_err = 1'b1;
            end
            state_next.rd_ack = CMD_RD_I && !state_next.cmd_err;
        end
        else if (CMD_WR_I || CMD_RD_I)
        begin
            // Before the straps are in, nothing may disturb the defaults.
            state_next.cmd_err = 1'b1;
        end

        state_next.busy = (state_next.state != ST_IDLE);
    end

    // The record is the only register; reset puts every field at a constant.
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            state_reg <= REGS_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the record.
    assign RD_DATA_O   = state_reg.rd_data;
    assign RD_ACK_O    = state_reg.rd_ack;
    assign CMD_ERR_O   = state_reg.cmd_err;
    assign FREQ_BUSY_O = state_reg.busy;
    assign DIVISOR_O   = state_reg.divisor;
    assign PH0_STEP_O  = state_reg.ph0;
    assign PH1_STEP_O  = state_reg.ph1;
    assign GAIN0_O     = state_reg.gain0;
    assign GAIN1_O     = state_reg.gain1;

    // Checks on the block's own behaviour.
    default clocking cb_main @(posedge CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    sequence s_strap_done;
        (state_reg.state == ST_STRAP) ##1 (state_reg.state == ST_SCAN);
    endsequence

    sequence s_scan_end;
        (state_reg.state == ST_SCAN) ##1 (state_reg.state == ST_IDLE);
    endsequence

    a_strap_target_load:
        assert property (s_strap_done |-> state_reg.target == $past(conv_khz))
        else $error("Strapped frequency was not loaded after reset.");

    a_scan_last_div:
        assert property (s_scan_end |-> $past(state_reg.scan_n) == DIV_MAX && !FREQ_BUSY_O)
        else $error("Divisor search ended early or busy stayed high.");

    a_div_in_range:
        assert property (DIVISOR_O >= DIV_MIN && DIVISOR_O <= DIV_MAX)
        else $error("Divisor left its legal range.");

    a_freq_write_restart:
        assert property (freq_wr |=> FREQ_BUSY_O && state_reg.scan_n == DIV_MIN
                                     && state_reg.target == $past(conv_khz))
        else $error("Frequency write did not restart the divisor search.");

    a_gain_reset_value:
        assert property ((state_reg.state == ST_STRAP) |->
                         GAIN0_O == GAIN_RST && GAIN1_O == GAIN_RST)
        else $error("Gain words lost their reset value.");

    a_phase_half_turn:
        assert property (PH0_STEP_O + STEPS_HALF == PH1_STEP_O
                         || PH0_STEP_O == PH1_STEP_O + STEPS_HALF)
        else $error("Phase 1 is not half a turn from phase 0.");

    a_phase_wrap_bound:
        assert property (PH0_STEP_O <= STEPS_FULL)
        else $error("Phase 0 offset exceeds a full turn.");

    a_solo_auto_phase:
        assert property (state_reg.solo_s2 |=> PH0_STEP_O == 5'h00 && PH1_STEP_O == STEPS_HALF)
        else $error("Solo group did not force automatic phases.");

    a_ilv_high_zero:
        assert property ((cmd_ok && CMD_RD_I && CMD_CODE_I == CMD_ILV) |=>
                         RD_ACK_O && RD_DATA_O[15:8] == 8'h00)
        else $error("Interleave read returned nonzero upper byte.");

    a_ilv_page_split:
        assert property ((cmd_ok && CMD_WR_I && CMD_CODE_I == CMD_ILV && !CMD_PAGE_I) |=>
                         $stable(state_reg.ilv1))
        else $error("Page 0 interleave write touched page 1.");

    a_gain_read_word:
        assert property ((cmd_ok && CMD_RD_I && !CMD_WR_I && CMD_CODE_I == CMD_GAIN
                          && !CMD_PAGE_I) |=> RD_DATA_O == $past(GAIN0_O))
        else $error("Gain read did not return the stored word.");

endmodule : switching_phase_config_regs

// ==== verification/mgmt_host_model.sv ====
// Behavioural management-bus host that issues command strobes to the register block.
`timescale 1ns/1ps
module mgmt_host_model
(
    input  wire logic        clk_i,
    input  wire logic        rd_ack_i,
    input  wire logic        cmd_err_i,
    input  wire logic [15:0] rd_data_i,
    output logic             cmd_wr_o,
    output logic             cmd_rd_o,
    output logic      [7:0]  cmd_code_o,
    output logic             cmd_page_o,
    output logic      [15:0] cmd_wdata_o
);

    // The bus starts idle, so nothing can be mistaken for a request at time zero.
    initial
    begin
        cmd_wr_o    = 1'b0;
        cmd_rd_o    = 1'b0;
        cmd_code_o  = 8'h00;
        cmd_page_o  = 1'b0;
        cmd_wdata_o = 16'h0000;
    end

    // One command: strobe after an edge, taken at the next, answer watched for two edges.
    // Released code and data lines get the inverse pattern, so a stale value can never pass as valid.
    task automatic xfer(input logic w, input logic [7:0] c, input logic p,
                        input logic [15:0] d, output logic [15:0] q,
                        output logic ack, output logic err);
        @(posedge clk_i);
        cmd_wr_o    <= w;
        cmd_rd_o    <= ~w;
        cmd_code_o  <= c;
        cmd_page_o  <= p;
        cmd_wdata_o <= d;
        @(posedge clk_i);
        cmd_wr_o    <= 1'b0;
        cmd_rd_o    <= 1'b0;
        cmd_code_o  <= ~c;
        cmd_wdata_o <= ~d;
        ack = 1'b0;
        err = 1'b0;
        q   = 16'h0000;
        repeat (2)
        begin
            #1;
            if (rd_ack_i === 1'b1)
            begin
                ack = 1'b1;
                q   = rd_data_i;
            end
            if (cmd_err_i === 1'b1)
            begin
                err = 1'b1;
            end
            @(posedge clk_i);
        end
    endtask : xfer

endmodule : mgmt_host_model

// ==== verification/switching_phase_config_regs_tb_top.sv ====
// Self-checking testbench for the switching, interleave and gain command registers.
`timescale 1ns/1ps
module switching_phase_config_regs_tb_top
    import swcfg_pkg::*;
;
    logic        clk;
    logic        resetn;
    logic        cmd_wr;
    logic        cmd_rd;
    logic [7:0]  cmd_code;
    logic        cmd_page;
    logic [15:0] cmd_wdata;
    logic [15:0] sync_strap;
    logic [7:0]  cfg_strap;
    logic        solo;
    logic [15:0] rd_data;
    logic        rd_ack;
    logic        cmd_err;
    logic        freq_busy;
    logic [6:0]  divisor;
    logic [4:0]  ph0;
    logic [4:0]  ph1;
    logic [15:0] gain0;
    logic [15:0] gain1;
    logic [15:0] q;
    logic        ack;
    logic        err;
    int          fails;
    int          comparisons;
    int          k;

    // Frequency words, expected divisor and read-back of the actual rate.
    logic [15:0] fw [4] = '{16'h03E8, 16'h0A99, 16'h0064, 16'h1A71};
    logic [6:0]  fn [4] = '{7'h10, 7'h0C, 7'h50, 7'h0C};
    logic [15:0] fr [4] = '{16'h03E8, 16'h0A9A, 16'h00C8, 16'h0A9A};
    // Interleave words and the phase steps expected for each.
    logic [15:0] iw [7] = '{16'h0041, 16'h0000, 16'h0031, 16'h0032, 16'h0013, 16'h0025,
                            16'hFF21};
    logic [4:0]  p0 [7] = '{5'h04, 5'h10, 5'h05, 5'h0B, 5'h10, 5'h08, 5'h08};
    logic [4:0]  p1 [7] = '{5'h0C, 5'h08, 5'h0D, 5'h03, 5'h08, 5'h10, 5'h10};

    // Free-running 200 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    switching_phase_config_regs switching_phase_config_regs_inst (
        .CLK_I        (clk),
        .RESETN_I     (resetn),
        .CMD_WR_I     (cmd_wr),
        .CMD_RD_I     (cmd_rd),
        .CMD_CODE_I   (cmd_code),
        .CMD_PAGE_I   (cmd_page),
        .CMD_WDATA_I  (cmd_wdata),
        .SYNC_STRAP_I (sync_strap),
        .CFG_STRAP_I  (cfg_strap),
        .SOLO_GROUP_I (solo),
        .RD_DATA_O    (rd_data),
        .RD_ACK_O     (rd_ack),
        .CMD_ERR_O    (cmd_err),
        .FREQ_BUSY_O  (freq_busy),
        .DIVISOR_O    (divisor),
        .PH0_STEP_O   (ph0),
        .PH1_STEP_O   (ph1),
        .GAIN0_O      (gain0),
        .GAIN1_O      (gain1)
    );

    mgmt_host_model host_inst (
        .clk_i       (clk),
        .rd_ack_i    (rd_ack),
        .cmd_err_i   (cmd_err),
        .rd_data_i   (rd_data),
        .cmd_wr_o    (cmd_wr),
        .cmd_rd_o    (cmd_rd),
        .cmd_code_o  (cmd_code),
        .cmd_page_o  (cmd_page),
        .cmd_wdata_o (cmd_wdata)
    );

    // Prints the counts and the verdict, then stops the run.
    task automatic conclude;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // Compares one value and counts the outcome.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // A good write must be silent: neither an answer nor a refusal.
    task automatic wr(input logic [7:0] c, input logic p, input logic [15:0] d);
        host_inst.xfer(1'b1, c, p, d, q, ack, err);
        check({14'h0000, ack, err}, 16'h0000);
    endtask : wr

    // A read must be answered, not refused, with the expected word.
    task automatic rd_check(input logic [7:0] c, input logic p, input logic [15:0] exp);
        host_inst.xfer(1'b0, c, p, 16'h0000, q, ack, err);
        check({14'h0000, ack, err}, 16'h0002);
        check(q, exp);
    endtask : rd_check

    // Waits for the divisor search to end; the bound covers a full scan with margin.
    task automatic wait_idle;
        int n;
        n = 0;
        #1;
        while (n < 300 && freq_busy !== 1'b0)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (freq_busy !== 1'b0)
        begin
            fails++;
            conclude();
        end
    endtask : wait_idle

    // Main sequence.
    initial
    begin
        fails       = 0;
        comparisons = 0;
        resetn      = 1'b0;
        sync_strap  = 16'h0190;
        cfg_strap   = 8'h41;
        solo        = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check(gain0, GAIN_RST);
        check(gain1, GAIN_RST);
        check(16'(divisor), 16'h0050);
        @(posedge clk);
        resetn <= 1'b1;
        // A command during start-up is refused.
        host_inst.xfer(1'b0, CMD_GAIN, 1'b0, 16'h0000, q, ack, err);
        check({14'h0000, ack, err}, 16'h0001);
        wait_idle();
        check(16'(divisor), 16'h0028);
        check(16'(ph0), 16'h0004);
        check(16'(ph1), 16'h000C);
        rd_check(CMD_FREQ, 1'b0, 16'h0190);
        rd_check(CMD_ILV, 1'b1, 16'h0041);
        // Unknown code is refused.
        host_inst.xfer(1'b0, 8'h34, 1'b0, 16'h0000, q, ack, err);
        check({14'h0000, ack, err}, 16'h0001);
        // Frequency writes, read back on the other page since the setting is global.
        for (k = 0; k < 4; k++)
        begin
            wr(CMD_FREQ, k[0], fw[k]);
            wait_idle();
            check(16'(divisor), 16'(fn[k]));
            rd_check(CMD_FREQ, ~k[0], fr[k]);
        end
        // A second write in mid-search restarts it with the new target.
        wr(CMD_FREQ, 1'b0, 16'h03E8);
        wr(CMD_FREQ, 1'b0, 16'h0064);
        wait_idle();
        check(16'(divisor), 16'h0050);
        // Interleave words on page 0 drive the phase outputs.
        for (k = 0; k < 7; k++)
        begin
            wr(CMD_ILV, 1'b0, iw[k]);
            repeat (3) @(posedge clk);
            #1;
            check(16'(ph0), 16'(p0[k]));
            check(16'(ph1), 16'(p1[k]));
            rd_check(CMD_ILV, 1'b0, {8'h00, iw[k][7:0]});
        end
        // Page 1 is held apart and does not steer the phases.
        wr(CMD_ILV, 1'b1, 16'h0031);
        repeat (3) @(posedge clk);
        #1;
        check(16'(ph0), 16'h0008);
        rd_check(CMD_ILV, 1'b1, 16'h0031);
        rd_check(CMD_ILV, 1'b0, 16'h0021);
        // A solo sharing group overrides the interleave word.
        @(posedge clk);
        solo <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check(16'(ph0), 16'h0000);
        check(16'(ph1), 16'h0008);
        @(posedge clk);
        solo <= 1'b0;
        // Gain is per page.
        wr(CMD_GAIN, 1'b1, 16'h1234);
        rd_check(CMD_GAIN, 1'b0, GAIN_RST);
        rd_check(CMD_GAIN, 1'b1, 16'h1234);
        check(gain1, 16'h1234);
        check(gain0, GAIN_RST);
        wr(CMD_GAIN, 1'b0, 16'h5678);
        rd_check(CMD_GAIN, 1'b0, 16'h5678);
        check(gain0, 16'h5678);
        conclude();
    end

endmodule : switching_phase_config_regs_tb_top
